// file: src/quad_counter_device.sv
// the counter end: 24-bit up/down counter with its host register port
// assumes bus pins and count pins are asynchronous and are synchronised here
`timescale 1ns/1ps
module quad_counter_device
   import quad_counter_pkg::*;
(
   input  wire logic   clk,              // 125 MHz
   input  wire logic   srst,             // synchronous reset, active high
   counter_bus_if.device bus,            // host port
   input  wire logic   count_a,          // count input a
   input  wire logic   count_b,          // count input b
   input  wire logic   gate_or_reset_n,  // gate or counter reset, active low
   input  wire logic   load_select_n,    // load counter or snapshot, active low
   output logic        carry_out,        // programmable carry pin
   output logic        borrow_out        // programmable borrow pin
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [15:0] pin_meta;  // first stage, read only by pin_sync
   logic [15:0] pin_sync;  // second stage
   logic        a_s, b_s, gate_n_s, load_n_s, cs_n_s, rd_n_s, wr_n_s, c_d_s;
   logic [7:0]  data_s;

   // two flops for every outside pin
   always_ff @(posedge clk) begin
      pin_meta <= {count_a, count_b, gate_or_reset_n, load_select_n,
                   bus.cs_n, bus.rd_n, bus.wr_n, bus.c_d, bus.data};
      pin_sync <= pin_meta;
   end
   assign {a_s, b_s, gate_n_s, load_n_s, cs_n_s, rd_n_s, wr_n_s, c_d_s, data_s} = pin_sync;

   // ---------------------------------------------------------------
   // bus strobe decode
   // ---------------------------------------------------------------
   logic rd_prev, wr_prev, load_prev;  // previous strobe levels
   logic wr_end, rd_end, ctrl_wr, data_wr, data_rd;

   // write taken when the strobe closes, data is then settled
   assign wr_end  = ~cs_n_s & wr_n_s & ~wr_prev;
   assign rd_end  = ~cs_n_s & rd_n_s & ~rd_prev;
   assign ctrl_wr = wr_end & c_d_s;
   assign data_wr = wr_end & ~c_d_s;
   assign data_rd = rd_end & ~c_d_s;

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_prev   <= 1'b1;
         wr_prev   <= 1'b1;
         load_prev <= 1'b1;
      end else begin
         rd_prev   <= rd_n_s;
         wr_prev   <= wr_n_s;
         load_prev <= load_n_s;
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   logic [5:0] input_control;           // input modes
   logic [5:0] output_counter_control;  // pin selects
   logic [5:0] quadrature_control;      // quadrature enable
   logic [5:0] mc_pulse;                // master actions, one cycle

   // four registers chosen by the two upper data bits
   always_ff @(posedge clk) begin
      if (srst) begin
         input_control          <= 6'h00;
         output_counter_control <= 6'h00;
         quadrature_control     <= 6'h00;
      end else if (ctrl_wr) begin
         case (data_s[7:6])
            SEL_INPUT:  input_control          <= data_s[5:0];
            SEL_OUTPUT: output_counter_control <= data_s[5:0];
            SEL_QUAD:   quadrature_control     <= data_s[5:0];
            default:    ;  // master holds no state
         endcase
      end
   end

   // each set action bit of a master write acts in the same cycle, except counter load when counter reset is also set
   assign mc_pulse = (ctrl_wr && data_s[7:6] == SEL_MASTER) ? data_s[5:0] : 6'h00;

   logic quad_on, a_down, b_dir, gate_is_reset, load_is_snap;
   assign quad_on       = quadrature_control[QC_ENABLE];
   assign a_down        = input_control[IC_A_DOWN];
   assign b_dir         = input_control[IC_B_DIR];
   assign gate_is_reset = input_control[IC_GATE_RESET];
   assign load_is_snap  = input_control[IC_LOAD_SNAP];

   // ---------------------------------------------------------------
   // quadrature validation filters
   // ---------------------------------------------------------------
   logic [1:0] filt_lvl;  // validated a (1) and b (0)

   // a level counts only after standing the full delay
   for (genvar i = 0; i < 2; i++) begin : g_filt
      logic [4:0] stable_cnt;  // cycles the raw level has differed
      logic       raw;
      assign raw = (i == 1) ? a_s : b_s;
      always_ff @(posedge clk) begin
         if (srst) begin
            stable_cnt  <= 5'h00;
            filt_lvl[i] <= 1'b0;
         end else if (raw == filt_lvl[i]) begin
            stable_cnt <= 5'h00;  // glitch ends, start over
         end else if (stable_cnt == 5'(QUAD_VALIDATION_CYC - 1)) begin
            filt_lvl[i] <= raw;
            stable_cnt  <= 5'h00;
         end else begin
            stable_cnt <= stable_cnt + 5'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // count step decode
   // ---------------------------------------------------------------
   logic a_lvl, b_lvl, a_prev, b_prev, step_up, step_dn, gate_ok, a_rise, b_rise;
   assign a_lvl   = quad_on ? filt_lvl[1] : a_s;
   assign b_lvl   = quad_on ? filt_lvl[0] : b_s;
   assign a_rise  = a_lvl & ~a_prev;
   assign b_rise  = b_lvl & ~b_prev;
   assign gate_ok = gate_is_reset | gate_n_s;

   always_ff @(posedge clk) begin
      if (srst) begin
         a_prev <= 1'b0;
         b_prev <= 1'b0;
      end else begin
         a_prev <= a_lvl;
         b_prev <= b_lvl;
      end
   end

   // one count per rising edge of a; b gives direction or its own clock
   always_comb begin
      step_up = 1'b0;
      step_dn = 1'b0;
      if (!gate_ok) begin
         step_up = 1'b0;  // gated off
      end else if (quad_on || b_dir) begin
         step_up = a_rise & ~b_lvl;
         step_dn = a_rise & b_lvl;
      end else begin
         // simultaneous up and down cancel out
         step_up = a_rise & ~a_down & ~b_rise;
         step_dn = (a_rise & a_down) | (b_rise & ~(a_rise & ~a_down));
      end
   end

   // ---------------------------------------------------------------
   // main counter, preset and snapshot
   // ---------------------------------------------------------------
   logic [23:0] main_counter;
   logic [23:0] preload_value;
   logic [23:0] count_snapshot;
   logic [1:0]  snap_ptr, preset_ptr;
   logic        ext_load, carry_ev, borrow_ev;

   assign ext_load  = ~load_n_s & load_prev;  // falling edge of load pin
   assign carry_ev  = step_up & (main_counter == COUNT_MAX);
   assign borrow_ev = step_dn & (main_counter == COUNT_ZERO);

   // reset beats load, load beats counting
   always_ff @(posedge clk) begin
      if (srst) begin
         main_counter <= COUNT_ZERO;
      end else if (mc_pulse[MC_CNT_RESET] || (gate_is_reset && !gate_n_s)) begin
         main_counter <= COUNT_ZERO;
      end else if (mc_pulse[MC_CNT_LOAD] || (ext_load && !load_is_snap)) begin
         main_counter <= preload_value;
      end else if (step_up) begin
         main_counter <= main_counter + 24'h000001;
      end else if (step_dn) begin
         main_counter <= main_counter - 24'h000001;
      end
   end

   // preset filled bytewise, pointer wraps after byte 2
   always_ff @(posedge clk) begin
      if (srst) begin
         preload_value <= COUNT_ZERO;
         preset_ptr    <= 2'h0;
      end else if (mc_pulse[MC_PTR_RESET]) begin
         preset_ptr <= 2'h0;
      end else if (data_wr) begin
         preload_value[preset_ptr*8 +: 8] <= data_s;
         preset_ptr <= (preset_ptr == BYTE_LAST) ? 2'h0 : preset_ptr + 2'h1;
      end
   end

   // snapshot copy and its read pointer
   always_ff @(posedge clk) begin
      if (srst) begin
         count_snapshot <= COUNT_ZERO;
      end else if (mc_pulse[MC_SNAP] || (ext_load && load_is_snap)) begin
         count_snapshot <= main_counter;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         snap_ptr <= 2'h0;
      end else if (mc_pulse[MC_PTR_RESET]) begin
         snap_ptr <= 2'h0;
      end else if (data_rd) begin
         snap_ptr <= (snap_ptr == BYTE_LAST) ? 2'h0 : snap_ptr + 2'h1;
      end
   end

   // ---------------------------------------------------------------
   // status flags
   // ---------------------------------------------------------------
   logic borrow_toggle, carry_toggle, compare_toggle, sign_flag, dir_flag;
   logic equal_now, equal_prev;
   logic [7:0] count_status;
   assign equal_now = (main_counter == preload_value);

   // events win over the flag reset of the same cycle
   always_ff @(posedge clk) begin
      if (srst || mc_pulse[MC_FLAG_RESET]) begin
         borrow_toggle  <= 1'b0;
         carry_toggle   <= 1'b0;
         compare_toggle <= 1'b0;
         sign_flag      <= 1'b0;
      end
      if (!srst) begin
         if (borrow_ev) borrow_toggle <= ~borrow_toggle;
         if (carry_ev) carry_toggle <= ~carry_toggle;
         if (equal_now && !equal_prev) compare_toggle <= ~compare_toggle;
         if (borrow_ev) sign_flag <= 1'b0;
         if (carry_ev) sign_flag <= 1'b1;
      end
   end

   // last direction seen, kept for quadrature reporting
   always_ff @(posedge clk) begin
      if (srst) begin
         equal_prev <= 1'b1;  // counter and preset both zero: no false compare edge
         dir_flag   <= 1'b1;
      end else begin
         equal_prev <= equal_now;
         if (step_up) dir_flag <= 1'b1;
         else if (step_dn) dir_flag <= 1'b0;
      end
   end

   assign count_status = {3'h0, (quad_on ? dir_flag : 1'b1), sign_flag,
                          compare_toggle, carry_toggle, borrow_toggle};

   // ---------------------------------------------------------------
   // read drive and output pins
   // ---------------------------------------------------------------
   logic carry_pulse, borrow_pulse;  // one cycle per event

   // data driven only while select and read are both low
   always_ff @(posedge clk) begin
      if (srst) begin
         bus.dev_doe  <= 1'b0;
         bus.dev_dout <= 8'h00;
      end else begin
         bus.dev_doe  <= ~cs_n_s & ~rd_n_s;
         bus.dev_dout <= c_d_s ? count_status : count_snapshot[snap_ptr*8 +: 8];
      end
   end

   // pins pick pulses, toggles or comparator
   always_ff @(posedge clk) begin
      if (srst) begin
         carry_pulse  <= 1'b0;
         borrow_pulse <= 1'b0;
         carry_out    <= 1'b1;
         borrow_out   <= 1'b1;
      end else begin
         carry_pulse  <= carry_ev;
         borrow_pulse <= borrow_ev;
         case (pin_sel_e'(output_counter_control[OC_CARRY_LO +: 2]))
            PIN_INV:  carry_out <= ~carry_pulse;
            PIN_TRUE: carry_out <= carry_pulse;
            PIN_TOG:  carry_out <= carry_toggle;
            PIN_COMP: carry_out <= ~equal_now;
            default:  carry_out <= 1'b1;
         endcase
         case (pin_sel_e'(output_counter_control[OC_BORROW_LO +: 2]))
            PIN_INV:  borrow_out <= ~borrow_pulse;
            PIN_TRUE: borrow_out <= borrow_pulse;
            PIN_TOG:  borrow_out <= borrow_toggle;
            PIN_COMP: borrow_out <= compare_toggle;
            default:  borrow_out <= 1'b1;
         endcase
      end
   end

endmodule

// file: src/quad_counter_pkg.sv
// constants, field layouts and state codes for the quadrature counter and its host port
// assumes a single 125 MHz clock shared by both ends of the 8-bit bus
package quad_counter_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS            = 8;    // 125 MHz
   localparam int QUAD_VALIDATION_DELAY_NS = 160;  // longest filter time
   // longest time: round down
   localparam int QUAD_VALIDATION_CYC      = QUAD_VALIDATION_DELAY_NS / CLK_PERIOD_NS;
   localparam int DATA_SETUP_NS            = 15;   // least times: round up
   localparam int STROBE_WIDTH_NS          = 60;
   localparam int DATA_HOLD_NS             = 30;
   localparam int SETUP_CYC  = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC   = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // widths and register selection
   // ---------------------------------------------------------------
   localparam int COUNT_W = 24;
   localparam logic [23:0] COUNT_MAX  = 24'hffffff;
   localparam logic [23:0] COUNT_ZERO = 24'h000000;
   localparam logic [1:0]  SEL_MASTER = 2'h0;  // data bits 7:6 of a control write
   localparam logic [1:0]  SEL_INPUT  = 2'h1;
   localparam logic [1:0]  SEL_OUTPUT = 2'h2;
   localparam logic [1:0]  SEL_QUAD   = 2'h3;
   localparam logic [1:0]  BYTE_LAST  = 2'h2;  // byte pointer runs 0..2

   // master_control bits (one-shot actions)
   localparam int MC_PTR_RESET   = 0;  // reset both byte pointers
   localparam int MC_SNAP        = 1;  // counter -> count_snapshot
   localparam int MC_CNT_RESET   = 2;  // counter -> 0
   localparam int MC_CNT_LOAD    = 3;  // preload_value -> counter
   localparam int MC_FLAG_RESET  = 4;  // clear toggles and sign
   // input_control bits
   localparam int IC_A_DOWN      = 0;  // a counts down when neither quadrature nor b direction is on
   localparam int IC_B_DIR       = 1;  // b is direction for a, else down clock
   localparam int IC_GATE_RESET  = 2;  // gate pin is counter reset, else gate
   localparam int IC_LOAD_SNAP   = 3;  // load pin loads snapshot, else counter
   // output_counter_control fields
   localparam int OC_CARRY_LO    = 0;  // carry pin select, 2 bits
   localparam int OC_BORROW_LO   = 2;  // borrow pin select, 2 bits
   // quadrature_control bits
   localparam int QC_ENABLE      = 0;

   // count_status bit positions
   localparam int ST_BORROW_T = 0;
   localparam int ST_CARRY_T  = 1;
   localparam int ST_COMP_T   = 2;
   localparam int ST_SIGN     = 3;
   localparam int ST_DIR      = 4;

   // output pin selections
   typedef enum logic [1:0] {
      PIN_INV   = 2'b00,  // complemented pulse, active low
      PIN_TRUE  = 2'b01,  // true pulse, active high
      PIN_TOG   = 2'b10,  // own toggle flip-flop
      PIN_COMP  = 2'b11   // carry: equal active low, borrow: compare toggle
   } pin_sel_e;

   // host strobe sequencer
   typedef enum logic [1:0] {
      H_IDLE   = 2'b00,
      H_SETUP  = 2'b01,
      H_STROBE = 2'b10,
      H_HOLD   = 2'b11
   } host_state_e;

endpackage

// file: src/counter_bus_if.sv
// the 8-bit host bus between the counter and its host processor
// assumes both ends run on the same clock; resolves the shared data lines
`timescale 1ns/1ps
interface counter_bus_if;
   logic       cs_n;       // chip select, active low
   logic       rd_n;       // read strobe, active low
   logic       wr_n;       // write strobe, active low
   logic       c_d;        // 1 control side, 0 data side
   logic [7:0] host_dout;  // host drive value
   logic       host_doe;   // host drives data
   logic [7:0] dev_dout;   // device drive value
   logic       dev_doe;    // device drives data
   logic [7:0] data;       // resolved bus level

   // undriven bus floats high through pull-ups
   assign data = dev_doe ? dev_dout : (host_doe ? host_dout : 8'hff);

   modport device (input cs_n, input rd_n, input wr_n, input c_d, input data,
                   output dev_dout, output dev_doe);
   modport host   (output cs_n, output rd_n, output wr_n, output c_d, input data,
                   output host_dout, output host_doe);
endinterface

// file: src/quad_counter_host.sv
// the host end: turns one request into a timed bus read or write
// assumes the counter end samples the bus pins through two flip-flops
`timescale 1ns/1ps
module quad_counter_host
   import quad_counter_pkg::*;
(
   input  wire logic       clk,       // 125 MHz
   input  wire logic       srst,      // synchronous reset, active high
   counter_bus_if.host     bus,       // bus to the counter
   input  wire logic       req,       // start a transfer, taken when idle
   input  wire logic       is_ctrl,   // 1 control side, 0 data side
   input  wire logic       is_write,  // 1 write, 0 read
   input  wire logic [7:0] wdata,     // write byte
   output logic            busy,      // transfer under way
   output logic            done,      // one-cycle end of transfer
   output logic [7:0]      rdata      // byte read, valid with done
);

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   host_state_e state;      // phase of the transfer
   logic [3:0]  phase_cnt;  // cycles left in a phase
   logic        op_write;   // latched direction

   // select and address first, then strobe, then hold with strobe high
   always_ff @(posedge clk) begin
      if (srst) begin
         state        <= H_IDLE;
         phase_cnt    <= 4'h0;
         op_write     <= 1'b0;
         busy         <= 1'b0;
         done         <= 1'b0;
         rdata        <= 8'h00;
         bus.cs_n     <= 1'b1;
         bus.rd_n     <= 1'b1;
         bus.wr_n     <= 1'b1;
         bus.c_d      <= 1'b0;
         bus.host_dout <= 8'h00;
         bus.host_doe <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            H_IDLE: if (req) begin
               state         <= H_SETUP;
               phase_cnt     <= 4'(SETUP_CYC - 1);
               op_write      <= is_write;
               busy          <= 1'b1;
               bus.cs_n      <= 1'b0;
               bus.c_d       <= is_ctrl;
               bus.host_dout <= wdata;
               bus.host_doe  <= is_write;  // data stands before the strobe
            end
            H_SETUP: if (phase_cnt == 4'h0) begin
               state     <= H_STROBE;
               phase_cnt <= 4'(STROBE_CYC - 1);
               bus.wr_n  <= ~op_write;
               bus.rd_n  <= op_write;
            end else begin
               phase_cnt <= phase_cnt - 4'h1;
            end
            H_STROBE: if (phase_cnt == 4'h0) begin
               state     <= H_HOLD;
               phase_cnt <= 4'(HOLD_CYC - 1);
               bus.wr_n  <= 1'b1;
               bus.rd_n  <= 1'b1;
               if (!op_write) rdata <= bus.data;  // sampled at strobe end
            end else begin
               phase_cnt <= phase_cnt - 4'h1;
            end
            H_HOLD: if (phase_cnt == 4'h0) begin
               // release the bus only after the counter saw the strobe close
               state        <= H_IDLE;
               busy         <= 1'b0;
               done         <= 1'b1;
               bus.cs_n     <= 1'b1;
               bus.host_doe <= 1'b0;
            end else begin
               phase_cnt <= phase_cnt - 4'h1;
            end
            default: state <= H_IDLE;
         endcase
      end
   end

endmodule

// file: tb/quad_counter_properties.sv
// bus checks between the counter end and the host end
// assumes one clock and the host's fixed pin sequence
`timescale 1ns/1ps
module quad_counter_properties (
   input wire logic       clk,       // bus clock
   input wire logic       srst,      // sync reset
   input wire logic       cs_n,      // select, low
   input wire logic       rd_n,      // read strobe
   input wire logic       wr_n,      // write strobe
   input wire logic       c_d,       // 1 control side
   input wire logic [7:0] host_dout, // host byte
   input wire logic       host_doe,  // host drives
   input wire logic [7:0] dev_dout,  // device byte
   input wire logic       dev_doe    // device drives
);
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   logic rd_sel;  // read strobe inside select
   assign rd_sel = !cs_n && !rd_n;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ---------------------------------------------
   // device drive: two-flop sync gives a lag of 2 to 4 edges
   // ---------------------------------------------
   a_doe_needs_read: assert property (
      dev_doe |-> $past(rd_sel, 2) || $past(rd_sel, 3) || $past(rd_sel, 4)) else $error("drive without read");
   a_read_answered: assert property (rd_sel [*6] |-> dev_doe)
      else $error("read not answered");
   a_doe_released: assert property (cs_n [*5] |-> !dev_doe)
      else $error("drive while deselected");
   a_no_bus_clash: assert property (!(dev_doe && host_doe))
      else $error("both ends drive");
   a_status_top_zero: assert property (dev_doe && c_d |-> dev_dout[7:5] == 3'h0)
      else $error("status top bits set");
   // ---------------------------------------------
   // host pin sequence
   // ---------------------------------------------
   a_strobe_selected: assert property (!rd_n || !wr_n |-> !cs_n)
      else $error("strobe outside select");
   a_write_held: assert property (
      $rose(wr_n) |-> (!cs_n && host_doe && $stable(host_dout) && $stable(c_d)) [*3]) else $error("write hold short");
   a_strobe_width: assert property ($fell(wr_n) |-> !wr_n [*8] ##1 wr_n)
      else $error("write strobe width");
   a_read_setup: assert property ($fell(rd_n) |-> $past(cs_n) == 1'b0)
      else $error("read before select");
endmodule

// file: tb/quadrature_counter_host_port_tb_top.sv
// bench joining host end and counter end over the bus
// assumes the fixed 15-edge host transfer of the package
`timescale 1ns/1ps
module quadrature_counter_host_port_tb_top import quad_counter_pkg::*;;
   // ---------------------------------------------
   // stimulus and scoreboard state
   // ---------------------------------------------
   logic        clk;                    // 125 MHz
   logic        srst          = 1'b1;   // reset held at start
   logic        req           = 1'b0;   // host request
   logic        is_ctrl       = 1'b0;   // control side
   logic        is_write      = 1'b0;   // write request
   logic [7:0]  wdata         = 8'h00;  // byte to write
   logic        count_a       = 1'b0;   // count clock
   logic        load_select_n = 1'b1;   // load pin, idle high
   logic        cur_rd        = 1'b0;   // transfer in flight reads
   logic        busy;                   // host busy
   logic        done;                   // host done pulse
   logic [7:0]  rdata;                  // host read byte
   logic        carry_pin;              // device carry pin
   logic        borrow_pin;             // device borrow pin
   logic [7:0]  exp_q[$];               // expected read bytes
   logic [31:0] seed          = 32'h0000158f;
   logic [23:0] val;                    // preset under test
   int          miscompares   = 0;
   int          n_tests       = 0;
   int          cycles        = 0;
   counter_bus_if counter_bus_if_i ();
   // count_b and gate stay idle: b would clash with a as down clock
   quad_counter_device quad_counter_device_i (.clk(clk), .srst(srst), .bus(counter_bus_if_i.device),
      .count_a(count_a), .count_b(1'b0), .gate_or_reset_n(1'b1), .load_select_n(load_select_n),
      .carry_out(carry_pin), .borrow_out(borrow_pin));
   quad_counter_host quad_counter_host_i (.clk(clk), .srst(srst), .bus(counter_bus_if_i.host), .req(req),
      .is_ctrl(is_ctrl), .is_write(is_write), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
   quad_counter_properties quad_counter_properties_i (.clk(clk), .srst(srst), .cs_n(counter_bus_if_i.cs_n),
      .rd_n(counter_bus_if_i.rd_n), .wr_n(counter_bus_if_i.wr_n), .c_d(counter_bus_if_i.c_d),
      .host_dout(counter_bus_if_i.host_dout), .host_doe(counter_bus_if_i.host_doe),
      .dev_dout(counter_bus_if_i.dev_dout), .dev_doe(counter_bus_if_i.dev_doe));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (miscompares == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // one host transfer; done is looked at off the edge
   task automatic xfer(input logic ctrl, input logic wr, input logic [7:0] d);
      int n;
      n = 0;
      req <= 1'b1;
      is_ctrl <= ctrl;
      is_write <= wr;
      wdata <= d;
      cur_rd <= !wr;
      @(posedge clk);
      req <= 1'b0;
      do begin
         @(negedge clk);
         n++;
      end while (done !== 1'b1 && n < 40);
      if (n >= 40) miscompares++;
      @(posedge clk);
   endtask
   task automatic rd(input logic ctrl, input logic [7:0] exp);
      exp_q.push_back(exp);
      xfer(ctrl, 1'b0, 8'h00);
   endtask
   task automatic pulse_a();
      count_a <= 1'b1;
      repeat (4) @(posedge clk);
      count_a <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // ---------------------------------------------
   // clock, watchdog, result watcher
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      // whole run needs about 760 edges
      if (cycles == 4000) begin
         miscompares++;
         stop_test();
      end
   end
   always @(negedge clk) begin
      if (done === 1'b1 && cur_rd) check(rdata, exp_q.pop_front());
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rd(1'b1, 8'h10);
      // preset, load, snapshot round trip: edges then random values
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         val = (i == 0) ? 24'hffffff : (i == 1) ? 24'h000000 : seed[23:0];
         for (int b = 0; b < 3; b++) xfer(1'b0, 1'b1, val[8*b +: 8]);
         xfer(1'b1, 1'b1, 8'h08);
         xfer(1'b1, 1'b1, 8'h03);
         for (int b = 0; b < 3; b++) rd(1'b0, val[8*b +: 8]);
      end
      // counter at all ones by load pin, then wrap up to zero
      for (int b = 0; b < 3; b++) xfer(1'b0, 1'b1, 8'hff);
      load_select_n <= 1'b0;
      repeat (4) @(posedge clk);
      load_select_n <= 1'b1;
      xfer(1'b1, 1'b1, 8'h10);
      rd(1'b1, 8'h10);
      pulse_a();
      rd(1'b1, 8'h1a);
      // both pins show their toggle flip-flops
      xfer(1'b1, 1'b1, 8'h8a);
      check({6'h00, carry_pin, borrow_pin}, 8'h02);
      xfer(1'b1, 1'b1, 8'h41);
      pulse_a();
      rd(1'b1, 8'h17);
      check({6'h00, carry_pin, borrow_pin}, 8'h03);
      xfer(1'b1, 1'b1, 8'h03);
      for (int b = 0; b < 3; b++) rd(1'b0, 8'hff);
      repeat (4) @(posedge clk);
      stop_test();
   end
endmodule
